// >>> hdl/sct_pkg.sv
/*
 Shared constants for the serial peripheral block: register offsets,
 field positions, reset values and delay figures.
 Assumes byte addresses on an 8-bit register port with 32-bit data.
*/
package sct_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h60;
   localparam logic [7:0] OFS_STAT = 8'h70;
   localparam logic [7:0] OFS_IEN  = 8'h74;
   localparam logic [7:0] OFS_IDIS = 8'h78;
   localparam logic [7:0] OFS_IMSK = 8'h7c;
   localparam logic [7:0] OFS_RXW  = 8'h80;
   localparam logic [7:0] OFS_TXW  = 8'h84;
   localparam logic [7:0] OFS_CFG0 = 8'h90;
   // Mode register fields
   localparam int MD_MASTER = 0;
   localparam int MD_VARSEL = 1;
   localparam int MD_EXTDEC = 2;
   localparam int MD_MASTER_CLOCK_DIV_SELECT  = 3;
   localparam int MD_CODE   = 16;
   localparam int MD_GAP    = 24;
   // Event bit positions in status and mask
   localparam int EV_RXF  = 0;
   localparam int EV_TXE  = 1;
   localparam int EV_MODE_FAULT_FLAG = 2;
   localparam int EV_OVR  = 3;
   localparam int EV_BLOCK_RX_END_FLAG = 4;
   localparam int EV_BLOCK_TX_END_FLAG = 5;
   localparam int PIN_LSB = 16;
   localparam int CODE_LSB = 16;
   // Writable mask bits: six events and seven pins
   localparam logic [31:0] IMSK_BITS = 32'h007f_003f;
   localparam logic [31:0] CFG_BITS  = 32'hffff_fff3;
   localparam logic [31:0] MODE_RST  = 32'h0000_0000;
   localparam logic [31:0] CFG_RST   = 32'h0000_0000;
   // Delay figures in master clock periods
   localparam logic [12:0] TRAIL_DEF = 13'h0004;
   localparam logic [12:0] GAP_MIN   = 13'h0006;
   localparam int          MASTER_CLOCK_DIV_SELECT_N   = 32;
   // Bits per word from the length code; reserved codes give 8
   function automatic logic [4:0] sct_nbits(input logic [3:0] code);
      return (code <= 4'h8) ? 5'(5'h08 + 5'(code)) : 5'h08;
   endfunction
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_LEAD  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_TRAIL = 3'b011,
      ST_GAP   = 3'b100
   } sct_state_t;
endpackage

// >>> hdl/sct_tick_gen.sv
/*
 Master clock enable: every core clock, or one in thirty-two.
 Assumes a single core clock and synchronous select input.
*/
`timescale 1ns/1ps
module sct_tick_gen (
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   input  wire logic div_sel_i,
   output logic      tick_o
);
   import sct_pkg::*;
   logic [4:0] pre_reg;

   // Prescaler runs always so the ratio is exact when selected
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_reg <= 5'h00;
         tick_o  <= 1'b0;
      end else begin
         pre_reg <= pre_reg + 5'h01;
         tick_o  <= !div_sel_i || (pre_reg == 5'(MASTER_CLOCK_DIV_SELECT_N - 1));
      end
   end
endmodule

// >>> hdl/sct_cs_decode.sv
/*
 Chip-select line decoder and configuration index selection.
 Purely combinational; the caller registers the outputs.
*/
`timescale 1ns/1ps
module sct_cs_decode (
   input  wire logic [3:0] code_i,
   input  wire logic       ext_dec_i,
   output logic      [3:0] cs_n_o,
   output logic      [1:0] idx_o
);
   // Direct mode drives the lowest zero bit; code 1111 selects none
   always_comb begin
      if (ext_dec_i) begin
         cs_n_o = code_i;
         idx_o  = code_i[3:2];
      end else if (!code_i[0]) begin
         cs_n_o = 4'he;
         idx_o  = 2'h0;
      end else if (!code_i[1]) begin
         cs_n_o = 4'hd;
         idx_o  = 2'h1;
      end else if (!code_i[2]) begin
         cs_n_o = 4'hb;
         idx_o  = 2'h2;
      end else begin
         cs_n_o = {code_i[3], 3'h7};
         idx_o  = 2'h3;
      end
   end
endmodule

// >>> hdl/sct_core.sv
/*
 Serial peripheral master: registers, chip selects, baud and delays.
 Assumes a register port with read data one cycle after the strobe,
 and event pulses for mode fault and block ends from outside.
*/
// Functional notes
// - Pin mask bits set/cleared by enable/disable writes
// - Six event masks gate each event request
// - Mode fault mask works only as master
// - Reading receive word clears receive-full
// - Received data right-justified, upper bits zero
// - Master captures chip selects at transfer end
// - Transmit select field used only when variable
// - Direct mode drives lowest zero code bit
// - External decode drives code onto selects
// - Serial clock idles at polarity bit level
// - Phase zero: change leading, sample following
// - Phase one: sample leading, change following
// - Length codes 0..8 give 8..16 bits
// - Reserved length codes give 8 bits
// - Clock is master clock over twice divisor
// - Divisor below two stops clock; reset disabled
// - Master clock is core or core/32
// - Select-to-clock delay, half period when zero
// - Post-transfer delay four, else 32 times field
// - Variable select takes code from transmit word
// - Receive-full set on load until read
// - Overrun on second load without read
`timescale 1ns/1ps
module sct_core (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        mode_fault_i,
   input  wire logic        block_rx_end_i,
   input  wire logic        block_tx_end_i,
   input  wire logic        miso_i,
   output logic             mosi_o,
   output logic             sclk_o,
   output logic      [3:0]  chip_select_out_n_o,
   output logic      [5:0]  event_req_o
);
   import sct_pkg::*;

   sct_state_t  state_reg;
   logic [31:0] mode_reg;
   logic [31:0] imsk_reg;
   logic [31:0] cfg_reg [4];
   logic [15:0] tx_hold_reg;
   logic [3:0]  tx_code_reg;
   logic        tx_empty_flag;
   logic        rx_full_flag;
   logic        mode_fault_flag;
   logic        overrun_flag;
   logic        block_rx_end_flag;
   logic        block_tx_end_flag;
   logic [15:0] rx_word_reg;
   logic [3:0]  rx_code_reg;
   logic [15:0] tx_sh_reg;
   logic [15:0] rx_sh_reg;
   logic [1:0]  idx_reg;
   logic [3:0]  code_reg;
   logic [7:0]  hcnt_reg;
   logic [4:0]  edge_reg;
   logic [12:0] dcnt_reg;
   logic        launch_reg;
   logic        done_reg;
   logic        tick;
   logic [3:0]  sel_code;
   logic [3:0]  dec_cs_n;
   logic [1:0]  dec_idx;
   logic [31:0] new_cfg;
   logic [31:0] cur_cfg;
   logic [4:0]  new_bits;
   logic [4:0]  cur_bits;
   logic        baud_ok;
   logic        leading;
   logic        smp_edge;
   logic        chg_edge;
   logic [15:0] rx_sh_next;
   logic        wr_txw;
   logic        rd_rxw;
   logic        rd_stat;
   logic        last_edge;
   logic [12:0] trail_n;

   sct_tick_gen u_tick (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .div_sel_i (mode_reg[MD_MASTER_CLOCK_DIV_SELECT]),
      .tick_o    (tick)
   );

   sct_cs_decode u_dec (
      .code_i    (sel_code),
      .ext_dec_i (mode_reg[MD_EXTDEC]),
      .cs_n_o    (dec_cs_n),
      .idx_o     (dec_idx)
   );

   // Target select and the configuration that goes with it
   always_comb begin
      sel_code = mode_reg[MD_VARSEL] ? tx_code_reg : mode_reg[MD_CODE +: 4];
      new_cfg  = cfg_reg[dec_idx];
      cur_cfg  = cfg_reg[idx_reg];
      new_bits = sct_nbits(new_cfg[7:4]);
      cur_bits = sct_nbits(cur_cfg[7:4]);
      baud_ok  = new_cfg[15:9] != 7'h00;
      leading  = !edge_reg[0];
      smp_edge = cur_cfg[1] ? leading : !leading;
      chg_edge = cur_cfg[1] ? !leading : (leading && edge_reg != 5'h00);
      rx_sh_next = smp_edge ? {rx_sh_reg[14:0], miso_i} : rx_sh_reg;
      last_edge = edge_reg == 5'({cur_bits, 1'b0} - 6'h01);
      trail_n  = (cur_cfg[31:24] == 8'h00) ? TRAIL_DEF
               : 13'({cur_cfg[31:24], 5'h00});
      wr_txw   = wr_i && addr_i == OFS_TXW;
      rd_rxw   = rd_i && addr_i == OFS_RXW;
      rd_stat  = rd_i && addr_i == OFS_STAT;
   end

   // Software-written configuration; reserved config bits stay zero, mode register keeps all 32 written bits
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_reg    <= MODE_RST;
         imsk_reg    <= 32'h0000_0000;
         tx_hold_reg <= 16'h0000;
         tx_code_reg <= 4'hf;
         for (int i = 0; i < 4; i++) begin
            cfg_reg[i] <= CFG_RST;
         end
      end else if (wr_i) begin
         case (addr_i)
            OFS_MODE: mode_reg <= wdata_i;
            OFS_IEN:  imsk_reg <= imsk_reg | (wdata_i & IMSK_BITS);
            OFS_IDIS: imsk_reg <= imsk_reg & ~wdata_i;
            OFS_TXW: begin
               tx_hold_reg <= wdata_i[15:0];
               tx_code_reg <= wdata_i[CODE_LSB +: 4];
            end
            default: begin
               if (addr_i[7:4] == OFS_CFG0[7:4] && addr_i[1:0] == 2'h0) begin
                  cfg_reg[addr_i[3:2]] <= wdata_i & CFG_BITS;
               end
            end
         endcase
      end
   end

   // Sticky flags; a set in the same cycle as its clear wins, except transmit-empty, where the transmit write beats the launch
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_empty_flag     <= 1'b1;
         rx_full_flag      <= 1'b0;
         mode_fault_flag   <= 1'b0;
         overrun_flag      <= 1'b0;
         block_rx_end_flag <= 1'b0;
         block_tx_end_flag <= 1'b0;
         rx_word_reg       <= 16'h0000;
         rx_code_reg       <= 4'h0;
      end else begin
         if (wr_txw) begin
            tx_empty_flag <= 1'b0;
         end else if (launch_reg) begin
            tx_empty_flag <= 1'b1;
         end
         if (done_reg) begin
            rx_word_reg  <= rx_sh_reg;
            rx_code_reg  <= chip_select_out_n_o;
            rx_full_flag <= 1'b1;
         end else if (rd_rxw) begin
            rx_full_flag <= 1'b0;
         end
         overrun_flag <= (done_reg && rx_full_flag && !rd_rxw)
                         || (overrun_flag && !rd_stat);
         mode_fault_flag   <= mode_fault_i || (mode_fault_flag && !rd_stat);
         block_rx_end_flag <= block_rx_end_i || (block_rx_end_flag && !rd_stat);
         block_tx_end_flag <= block_tx_end_i || (block_tx_end_flag && !rd_stat);
      end
   end

   // Event requests gated by their masks
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         event_req_o <= 6'h00;
      end else begin
         event_req_o[EV_RXF]  <= rx_full_flag && imsk_reg[EV_RXF];
         event_req_o[EV_TXE]  <= tx_empty_flag && imsk_reg[EV_TXE];
         event_req_o[EV_MODE_FAULT_FLAG] <= mode_fault_flag && imsk_reg[EV_MODE_FAULT_FLAG]
                                 && mode_reg[MD_MASTER];
         event_req_o[EV_OVR]  <= overrun_flag && imsk_reg[EV_OVR];
         event_req_o[EV_BLOCK_RX_END_FLAG] <= block_rx_end_flag && imsk_reg[EV_BLOCK_RX_END_FLAG];
         event_req_o[EV_BLOCK_TX_END_FLAG] <= block_tx_end_flag && imsk_reg[EV_BLOCK_TX_END_FLAG];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (!rd_i) begin
         rdata_o <= 32'h0000_0000;
      end else begin
         case (addr_i)
            OFS_MODE: rdata_o <= mode_reg;
            OFS_STAT: rdata_o <= {26'h0, block_tx_end_flag, block_rx_end_flag,
                                  overrun_flag, mode_fault_flag,
                                  tx_empty_flag, rx_full_flag};
            OFS_IMSK: rdata_o <= imsk_reg;
            OFS_RXW:  rdata_o <= {12'h0, rx_code_reg, rx_word_reg};
            default: begin
               if (addr_i[7:4] == OFS_CFG0[7:4] && addr_i[1:0] == 2'h0) begin
                  rdata_o <= cfg_reg[addr_i[3:2]];
               end else begin
                  rdata_o <= 32'h0000_0000;
               end
            end
         endcase
      end
   end

   // Transfer sequencer; all timing counts master clock ticks
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg  <= ST_IDLE;
         sclk_o     <= 1'b0;
         chip_select_out_n_o <= 4'hf;
         tx_sh_reg  <= 16'h0000;
         rx_sh_reg  <= 16'h0000;
         idx_reg    <= 2'h0;
         code_reg   <= 4'hf;
         hcnt_reg   <= 8'h00;
         edge_reg   <= 5'h00;
         dcnt_reg   <= 13'h0000;
         launch_reg <= 1'b0;
         done_reg   <= 1'b0;
      end else begin
         launch_reg <= 1'b0;
         done_reg   <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               sclk_o <= new_cfg[0];
               if (mode_reg[MD_MASTER] && !tx_empty_flag && baud_ok && !launch_reg) begin
                  state_reg  <= ST_LEAD;
                  chip_select_out_n_o <= dec_cs_n;
                  idx_reg    <= dec_idx;
                  code_reg   <= sel_code;
                  tx_sh_reg  <= tx_hold_reg << (5'h10 - new_bits);
                  rx_sh_reg  <= 16'h0000;
                  hcnt_reg   <= 8'h00;
                  edge_reg   <= 5'h00;
                  launch_reg <= 1'b1;
                  dcnt_reg   <= (new_cfg[23:16] == 8'h00)
                                ? 13'(new_cfg[15:8] - 8'h01)
                                : 13'(new_cfg[23:16] - 8'h01);
               end
            end
            ST_LEAD: begin
               sclk_o <= cur_cfg[0];
               if (tick) begin
                  if (dcnt_reg == 13'h0000) begin
                     // First edge ends the delay itself, not one half period later
                     state_reg <= ST_SHIFT;
                     sclk_o    <= !cur_cfg[0];
                     rx_sh_reg <= rx_sh_next;
                     edge_reg  <= 5'h01;
                  end else begin
                     dcnt_reg <= dcnt_reg - 13'h0001;
                  end
               end
            end
            ST_SHIFT: begin
               // Divisor changes mid-word take effect in the half period already under way
               if (cur_cfg[15:9] == 7'h00) begin
                  state_reg <= ST_GAP;
                  sclk_o    <= cur_cfg[0];
                  chip_select_out_n_o <= 4'hf;
                  dcnt_reg  <= GAP_MIN;
               end else if (tick) begin
                  if (hcnt_reg == 8'(cur_cfg[15:8] - 8'h01)) begin
                     hcnt_reg  <= 8'h00;
                     sclk_o    <= !sclk_o;
                     rx_sh_reg <= rx_sh_next;
                     edge_reg  <= edge_reg + 5'h01;
                     if (chg_edge) begin
                        tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
                     end
                     if (last_edge) begin
                        state_reg <= ST_TRAIL;
                        done_reg  <= 1'b1;
                        dcnt_reg  <= 13'(trail_n - 13'h0001);
                     end
                  end else begin
                     hcnt_reg <= hcnt_reg + 8'h01;
                  end
               end
            end
            ST_TRAIL: begin
               if (tick) begin
                  if (dcnt_reg != 13'h0000) begin
                     dcnt_reg <= dcnt_reg - 13'h0001;
                  end else if (!tx_empty_flag && sel_code == code_reg
                               && mode_reg[MD_MASTER] && baud_ok && !launch_reg) begin
                     // Same peripheral: keep the select, no lead delay
                     state_reg  <= ST_SHIFT;
                     tx_sh_reg  <= tx_hold_reg << (5'h10 - cur_bits);
                     rx_sh_reg  <= 16'h0000;
                     hcnt_reg   <= 8'h00;
                     edge_reg   <= 5'h00;
                     launch_reg <= 1'b1;
                  end else begin
                     state_reg <= ST_GAP;
                     chip_select_out_n_o <= 4'hf;
                     dcnt_reg  <= (13'(mode_reg[MD_GAP +: 8]) < GAP_MIN)
                                  ? GAP_MIN : 13'(mode_reg[MD_GAP +: 8]);
                  end
               end
            end
            ST_GAP: begin
               sclk_o <= cur_cfg[0];
               if (tick) begin
                  if (dcnt_reg <= 13'h0001) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     dcnt_reg <= dcnt_reg - 13'h0001;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   assign mosi_o = tx_sh_reg[15];

   // Checks on the behaviour above
   sequence s_launch;
      state_reg == ST_IDLE && mode_reg[MD_MASTER] && !tx_empty_flag
      && baud_ok && !launch_reg;
   endsequence

   sequence s_word_done;
      done_reg && rx_full_flag && !rd_rxw;
   endsequence

   a_cs_on_launch: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      s_launch |=> chip_select_out_n_o == $past(dec_cs_n) && state_reg == ST_LEAD)
      else $error("chip select not driven from decoded code");

   a_sclk_idle_level: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_IDLE) ##1 (state_reg == ST_IDLE) |-> sclk_o == $past(new_cfg[0]))
      else $error("serial clock not at idle level");

   a_baud_off_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_IDLE && !baud_ok) |=> state_reg == ST_IDLE)
      else $error("transfer started with baud generator off");

   a_rx_read_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (rd_rxw && !done_reg) |=> !rx_full_flag)
      else $error("receive-full not cleared by read");

   a_rx_load_sets: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_reg |=> rx_full_flag && rx_word_reg == $past(rx_sh_reg))
      else $error("receive word not loaded");

   a_overrun_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      s_word_done |=> overrun_flag)
      else $error("overrun not flagged");

   a_rx_upper_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_reg |=> (rx_word_reg >> $past(cur_bits)) == 16'h0000)
      else $error("bits above word length not zero");

   a_mask_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_i && addr_i == OFS_IEN) |=> (imsk_reg & $past(wdata_i & IMSK_BITS))
                                      == $past(wdata_i & IMSK_BITS))
      else $error("mask enable write lost");

   a_mask_disable: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (wr_i && addr_i == OFS_IDIS) |=> (imsk_reg & $past(wdata_i)) == 32'h0000_0000)
      else $error("mask disable write lost");

   a_mode_fault_flag_slave: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !mode_reg[MD_MASTER] |=> !event_req_o[EV_MODE_FAULT_FLAG])
      else $error("mode fault request in slave operation");

   a_cs_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_reg |=> rx_code_reg == $past(chip_select_out_n_o))
      else $error("chip select state not captured");
endmodule

// >>> verif/sct_slave_model.sv
/*
 Serial slave on the far side of the core: shifts a word out, captures one in.
 Assumes it is selected while any select line differs from all ones.
*/
`timescale 1ns/1ps
module sct_slave_model (
   input  wire logic        sclk_i,
   input  wire logic [3:0]  cs_n_i,
   input  wire logic        mosi_i,
   input  wire logic        cpol_i,
   input  wire logic        cpha_i,
   input  wire logic [4:0]  nbits_i,
   input  wire logic [15:0] word_i,
   output logic             miso_o,
   output logic      [15:0] rx_o
);
   logic sel;
   logic sel_q;
   int   idx;
   int   got;
   assign sel = (cs_n_i != 4'hf);
   // One process owns the model state; a select change is told from a clock edge
   always @(sel or sclk_i) begin
      if (sel !== sel_q) begin
         sel_q = sel;
         // Top bit shown on select; released line shows the inverse, not a held value
         if (sel) begin
            idx = nbits_i - 1;
            got = 0;
            rx_o = 16'h0;
            miso_o = word_i[idx];
         end else begin
            miso_o = ~miso_o;
         end
      end else if (sel) begin
         // Sample on leading edge when phase set, else on following edge
         if ((sclk_i != cpol_i) == cpha_i) begin
            rx_o = {rx_o[14:0], mosi_i};
            got++;
         end else if (got > 0 && idx > 0) begin
            idx--;
            miso_o = word_i[idx];
         end
      end
   end
endmodule

// >>> verif/testbench.sv
/*
 Self-checking bench for the serial core with a slave model on its pins.
 Assumes a 20 MHz core clock and the register map of the shared package.
*/
`timescale 1ns/1ps
module testbench;
   import sct_pkg::*;
   logic        clk, rst_b, wr, rd, mf, bre, bte, miso, mosi, sclk, pol, pha, last_sclk;
   logic [7:0]  addr, hp, cnt;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  cs_n, seen_cs;
   logic [5:0]  ev;
   logic [15:0] slv_word, slv_rx;
   logic [4:0]  nb;
   int          seed = 70;
   int          mismatches = 0;
   int          checks = 0;

   sct_core i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mode_fault_i(mf), .block_rx_end_i(bre),
      .block_tx_end_i(bte), .miso_i(miso), .mosi_o(mosi), .sclk_o(sclk),
      .chip_select_out_n_o(cs_n), .event_req_o(ev));
   sct_slave_model i_slave (.sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .cpol_i(pol),
      .cpha_i(pha), .nbits_i(nb), .word_i(slv_word), .miso_o(miso), .rx_o(slv_rx));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Half period in core cycles
   always @(posedge clk) begin
      cnt <= (sclk != last_sclk) ? 8'h01 : cnt + 8'h01;
      if (sclk != last_sclk) hp <= cnt;
      last_sclk <= sclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic pulse;
      @(posedge clk);
      {mf, bre, bte} <= 3'b111;
      @(posedge clk);
      {mf, bre, bte} <= 3'b000;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Expected direct select lines: lowest zero bit of the code wins
   function automatic logic [3:0] dec(input logic [3:0] c);
      casez (c)
         4'b???0: return 4'he;
         4'b??01: return 4'hd;
         4'b?011: return 4'hb;
         default: return 4'h7;
      endcase
   endfunction

   // One word with random polarity, phase, divisor and lead delay
   task automatic xfer(input logic [3:0] code, input logic ext, input logic d32,
                       input logic [3:0] len, input logic rdb);
      logic [31:0] r;
      logic [7:0]  div;
      logic [15:0] msk;
      logic [3:0]  ecs;
      int          n;
      r = $random(seed);
      {pha, pol} = r[1:0];
      div = d32 ? 8'h02 : 8'h02 + 8'(r[9:8]) % 8'h03;
      nb = (len <= 4'h8) ? 5'h08 + 5'(len) : 5'h08;
      msk = 16'((17'h1 << nb) - 17'h1);
      ecs = ext ? code : dec(code);
      slv_word = r[31:16];
      for (int i = 0; i < 4; i++) begin
         wreg(OFS_CFG0 + 8'(4 * i), {14'h0, r[11:10], div, len, 2'b00, pha, pol});
      end
      wreg(OFS_MODE, {12'h0, 4'hd, 12'h0, d32, ext, 2'b11});
      repeat (3) @(posedge clk);
      #1 chk(32'(sclk), 32'(pol));
      seen_cs = 4'hf;
      r = $random(seed);
      wreg(OFS_TXW, {12'h0, code, r[15:0]});
      n = 0;
      while (!(seen_cs !== 4'hf && cs_n === 4'hf) && n < 6000) begin
         @(posedge clk);
         #1 n++;
         if (cs_n !== 4'hf) seen_cs = cs_n;
      end
      chk(32'(n < 6000), 32'h1);
      chk(32'(ev[0]), 32'h1);
      chk(32'(hp), d32 ? 32'(div) * 32 : 32'(div));
      chk(32'(seen_cs), 32'(ecs));
      chk(32'(slv_rx & msk), 32'(r[15:0] & msk));
      if (rdb) begin
         rreg(OFS_RXW, d);
         chk(d, {12'h0, ecs, slv_word & msk});
         repeat (2) @(posedge clk);
         #1 chk(32'(ev[0]), 32'h0);
      end
      repeat (400) @(posedge clk);
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      end_sim();
   end

   initial begin
      logic [31:0] r1, r2;
      logic [3:0]  code;
      logic [3:0]  prev;
      int          k;
      {wr, rd, mf, bre, bte, pol, pha} = 7'h0;
      {addr, wdata, nb, slv_word} = '0;
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      // Mask set and clear, config read back, unmapped read
      for (int i = 0; i < 4; i++) begin
         r1 = $random(seed);
         r2 = $random(seed);
         wreg(OFS_IDIS, 32'hffff_ffff);
         wreg(OFS_IEN, r1);
         wreg(OFS_IDIS, r2);
         rreg(OFS_IMSK, d);
         chk(d, r1 & ~r2 & IMSK_BITS);
         wreg(OFS_CFG0 + 8'(4 * i), r1);
         rreg(OFS_CFG0 + 8'(4 * i), d);
         chk(d, r1 & CFG_BITS);
      end
      rreg(8'h44, d);
      chk(d, 32'h0);
      done("registers");
      // Event gating, mode fault only counts as master
      wreg(OFS_IDIS, 32'hffff_ffff);
      wreg(OFS_IEN, 32'h3f);
      pulse();
      chk(32'(ev), 32'h32);
      rreg(OFS_STAT, d);
      wreg(OFS_MODE, 32'h1);
      pulse();
      chk(32'(ev), 32'h36);
      rreg(OFS_STAT, d);
      wreg(OFS_IDIS, 32'h3e);
      repeat (2) @(posedge clk);
      #1 chk(32'(ev), 32'h0);
      done("events");
      // Every length code, select class and decode mode
      for (int i = 0; i < 16; i++) begin
         r1 = $random(seed);
         case (i)
            0: code = {r1[3:1], 1'b0};
            1: code = {r1[3:2], 2'b01};
            2: code = {r1[3], 3'b011};
            3: code = 4'h7;
            default: code = (r1[3:0] == 4'hf) ? 4'h3 : r1[3:0];
         endcase
         xfer(code, i >= 4 && i < 10, i == 15, 4'(i), 1'b1);
      end
      done("transfers");
      xfer(4'h0, 1'b0, 1'b0, 4'h0, 1'b0);
      xfer(4'h0, 1'b0, 1'b0, 4'h8, 1'b0);
      rreg(OFS_STAT, d);
      chk(d & 32'h9, 32'h9);
      rreg(OFS_RXW, d);
      done("overrun");
      // Two words to one peripheral: select stays low between them
      k = 0;
      prev = cs_n;
      wreg(OFS_TXW, 32'h0000_a5c3);
      wreg(OFS_TXW, 32'h0000_3c5a);
      repeat (600) begin
         @(posedge clk);
         #1 k += (cs_n !== prev);
         prev = cs_n;
      end
      chk(32'(k), 32'h2);
      chk(32'(slv_rx), 32'h3c5a);
      done("back to back");
      // Divisor one: clock parked at polarity one, nothing selected
      seen_cs = 4'hf;
      for (int i = 0; i < 4; i++) wreg(OFS_CFG0 + 8'(4 * i), 32'h0000_0101);
      wreg(OFS_TXW, 32'h0000_1234);
      repeat (300) begin
         @(posedge clk);
         #1 seen_cs &= cs_n;
      end
      chk(32'({sclk, seen_cs}), 32'h1f);
      done("disabled");
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1 chk(32'({sclk, cs_n, ev}), 32'h0f << 6);
      @(posedge clk);
      rst_b <= 1'b1;
      rreg(OFS_CFG0, d);
      chk(d, CFG_RST);
      done("reset");
      end_sim();
   end
endmodule
